// [rtl/dccu_top.sv]
`timescale 1ns/100ps
`include "dccu_map.svh"
// Functional notes
// - Each unit holds 16-bit value, two bytes
// - Mode zero disables and resets the unit
// - Modes 4-7 capture fall/rise/4th/16th rise
// - Mode 8 match drives pin high, flags
// - Mode 9 match drives pin low, flags
// - Mode 10 match only sets flag
// - Mode 11 flags, clears timer, unit two converts
// - Modes 11xx PWM, duty from low byte
// - Capture copies full timer count
// - Capture sets flag, software clears it
// - New capture overwrites old, no overrun
// - Events watch pin level, outputs included
// - Prescaler cleared when off or not capturing
// - Prescale switch keeps prescaler count
// - Compare acts in the match cycle
// - Both PWMs share one timer two timebase
// - Control written zero forces output latch low
// - Trigger clear never sets timer overflow flag
// - Software timer write beats trigger clear
module dccu_top #(
  parameter int TIMER_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [1:0]  unit_pin_i,
  output logic      [1:0]  unit_pin_o,
  input  wire logic        timer_one_tick_i,
  input  wire logic [7:0]  timer_two_count_i,
  input  wire logic [1:0]  timer_two_fine_i,
  input  wire logic        timer_two_match_i,
  input  wire logic        adc_enable_i,
  output logic             adc_start_o
);

  if (TIMER_W != 16) begin : g_bad_width
    $error("Timer width must be 16");
  end

  default clocking dccu_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [1:0]  pin_s1;
  logic [1:0]  pin_s2;
  logic [1:0]  pin_s3;
  logic [`DCCU_CTRL_W-1:0] ctrl [2];
  logic [7:0]  val_lo [2];
  logic [7:0]  val_hi [2];
  logic [3:0]  presc [2];
  logic [1:0]  duty_lat [2];
  logic [1:0]  flag;
  logic        ovf_flag;
  logic [15:0] timer_one_count;
  logic [7:0]  idx;
  logic        wr;
  logic        flags_wr;
  logic        tmr_wr;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  cap_evt;
  logic [1:0]  cmp_hit;
  logic [1:0]  trig;
  dccu_pkg::dccu_kind_e kind [2];

  function automatic dccu_pkg::dccu_kind_e kind_of(input logic [3:0] m);
    unique casez (m)
      4'b0000: kind_of = dccu_pkg::DCCU_OFF;
      4'b01??: kind_of = dccu_pkg::DCCU_CAPTURE;
      4'b10??: kind_of = dccu_pkg::DCCU_COMPARE;
      4'b11??: kind_of = dccu_pkg::DCCU_PWM;
      default: kind_of = dccu_pkg::DCCU_OFF;
    endcase
  endfunction

  function automatic logic [7:0] unit_idx(input int u, input int which);
    logic [7:0] r;
    r = 8'h00;
    unique case (which)
      0: r = (u == 0) ? `DCCU_IDX_U0_LO : `DCCU_IDX_U1_LO;
      1: r = (u == 0) ? `DCCU_IDX_U0_HI : `DCCU_IDX_U1_HI;
      default: r = (u == 0) ? `DCCU_IDX_U0_CTRL : `DCCU_IDX_U1_CTRL;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int u = 0; u < 2; u++) begin
      if (a == unit_idx(u, 0)) r = val_lo[u];
      if (a == unit_idx(u, 1)) r = val_hi[u];
      if (a == unit_idx(u, 2)) r = {2'b00, ctrl[u]};
    end
    if (a == `DCCU_IDX_TMR_LO) r = timer_one_count[7:0];
    if (a == `DCCU_IDX_TMR_HI) r = timer_one_count[15:8];
    if (a == `DCCU_IDX_FLAGS) r = {5'b00000, ovf_flag, flag};
    return r;
  endfunction

  assign idx      = adr_i[9:2];
  assign wr       = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  assign flags_wr = wr && (idx == `DCCU_IDX_FLAGS);
  assign tmr_wr   = wr && (idx == `DCCU_IDX_TMR_LO ||
                           idx == `DCCU_IDX_TMR_HI);

  // Ack a cycle after the request; drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= {24'h000000, read_byte(idx)};
    end
  end

  // Pad level, so port writes on an output pin also count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 2'b00;
      pin_s2 <= 2'b00;
      pin_s3 <= 2'b00;
    end else begin
      pin_s1 <= unit_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      kind[u]    = kind_of(ctrl[u][`DCCU_MODE_HI:0]);
      rise[u]    = pin_s2[u] & ~pin_s3[u];
      fall[u]    = ~pin_s2[u] & pin_s3[u];
      cmp_hit[u] = (kind[u] == dccu_pkg::DCCU_COMPARE) &&
                   ({val_hi[u], val_lo[u]} == timer_one_count);
      trig[u]    = cmp_hit[u] &&
                   (ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_TRIG);
      cap_evt[u] = 1'b0;
      unique case (ctrl[u][`DCCU_MODE_HI:0])
        `DCCU_MODE_FALL:   cap_evt[u] = fall[u];
        `DCCU_MODE_RISE:   cap_evt[u] = rise[u];
        `DCCU_MODE_RISE4:  cap_evt[u] = rise[u] &&
                           ({2'b00, presc[u][1:0]} == `DCCU_PS4_LAST);
        `DCCU_MODE_RISE16: cap_evt[u] = rise[u] &&
                           (presc[u] == `DCCU_PS16_LAST);
        default:           cap_evt[u] = 1'b0;
      endcase
    end
  end

  // Control and value registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int u = 0; u < 2; u++) begin
        ctrl[u]   <= `DCCU_CTRL_RST;
        val_lo[u] <= 8'h00;
        val_hi[u] <= 8'h00;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr && idx == unit_idx(u, 2))
          ctrl[u] <= dat_i[`DCCU_CTRL_W-1:0];
        if (cap_evt[u]) begin
          // Silent overwrite: no overrun tracking
          {val_hi[u], val_lo[u]} <= timer_one_count;
        end else begin
          if (wr && idx == unit_idx(u, 0))
            val_lo[u] <= dat_i[7:0];
          // High byte holds the active duty and is read-only in PWM
          if (kind[u] == dccu_pkg::DCCU_PWM) begin
            if (timer_two_match_i)
              val_hi[u] <= val_lo[u];
          end else if (wr && idx == unit_idx(u, 1)) begin
            val_hi[u] <= dat_i[7:0];
          end
        end
      end
    end
  end

  // Mode changes between prescales do not clear the count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int u = 0; u < 2; u++)
        presc[u] <= 4'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (kind[u] != dccu_pkg::DCCU_CAPTURE)
          presc[u] <= 4'h0;
        else if (rise[u])
          presc[u] <= presc[u] + 4'h1;
      end
    end
  end

  // Output latch, separate from any port data latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_pin_o <= 2'b00;
      for (int u = 0; u < 2; u++)
        duty_lat[u] <= 2'b00;
    end else begin
      for (int u = 0; u < 2; u++) begin
        unique case (kind[u])
          dccu_pkg::DCCU_OFF:
            unit_pin_o[u] <= 1'b0;
          dccu_pkg::DCCU_COMPARE: begin
            if (cmp_hit[u] &&
                ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_SET)
              unit_pin_o[u] <= 1'b1;
            else if (cmp_hit[u] &&
                     ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_CLR)
              unit_pin_o[u] <= 1'b0;
          end
          dccu_pkg::DCCU_PWM: begin
            // Shared period match keeps both rising edges aligned
            if (timer_two_match_i) begin
              duty_lat[u]   <= ctrl[u][`DCCU_DUTY_HI:`DCCU_DUTY_LO];
              unit_pin_o[u] <= |{val_lo[u],
                                 ctrl[u][`DCCU_DUTY_HI:`DCCU_DUTY_LO]};
            end else if ({val_hi[u], duty_lat[u]} ==
                         {timer_two_count_i, timer_two_fine_i}) begin
              unit_pin_o[u] <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 2'b00;
    end else begin
      for (int u = 0; u < 2; u++)
        flag[u] <= cap_evt[u] | cmp_hit[u] |
                   (flag[u] & ~(flags_wr & dat_i[u]));
    end
  end

  // Timer one count and its overflow flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_one_count <= 16'h0000;
      ovf_flag        <= 1'b0;
    end else begin
      if (tmr_wr) begin
        if (idx == `DCCU_IDX_TMR_LO)
          timer_one_count[7:0] <= dat_i[7:0];
        else
          timer_one_count[15:8] <= dat_i[7:0];
      end else if (|trig) begin
        timer_one_count <= 16'h0000;
      end else if (timer_one_tick_i) begin
        timer_one_count <= timer_one_count + 16'h0001;
      end
      // Only a natural wrap raises it, never the trigger clear
      ovf_flag <= (timer_one_tick_i && !tmr_wr && !(|trig) &&
                   &timer_one_count) |
                  (ovf_flag & ~(flags_wr & dat_i[`DCCU_FLAG_OVF]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      adc_start_o <= 1'b0;
    else
      adc_start_o <= trig[1] & adc_enable_i;
  end

  for (genvar u = 0; u < 2; u++) begin : g_chk
    a_capture_copy: assert property (
      cap_evt[u] |=> {val_hi[u], val_lo[u]} == $past(timer_one_count))
      else $error("Capture did not copy the timer");
    a_capture_flag: assert property (cap_evt[u] |=> flag[u])
      else $error("Capture flag not set");
    a_presc_clear: assert property (
      kind[u] != dccu_pkg::DCCU_CAPTURE |=> presc[u] == 4'h0)
      else $error("Prescaler not cleared");
    a_cmp_set_pin: assert property (
      cmp_hit[u] && ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_SET
      |=> unit_pin_o[u] && flag[u])
      else $error("Set on match failed");
    a_cmp_clr_pin: assert property (
      cmp_hit[u] && ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_CLR
      |=> !unit_pin_o[u] && flag[u])
      else $error("Clear on match failed");
    a_soft_keeps_pin: assert property (
      cmp_hit[u] && ctrl[u][`DCCU_MODE_HI:0] == `DCCU_MODE_SOFT
      |=> $stable(unit_pin_o[u]))
      else $error("Soft match moved the pin");
    a_off_latch_low: assert property (
      ctrl[u] == `DCCU_CTRL_RST |=> !unit_pin_o[u] && presc[u] == 4'h0)
      else $error("Off unit latch not low");
  end

  a_trig_clears: assert property (
    (|trig) && !tmr_wr |=> timer_one_count == 16'h0000 && !$rose(ovf_flag))
    else $error("Trigger did not clear timer");
  a_write_wins: assert property (
    (|trig) && wr && idx == `DCCU_IDX_TMR_LO
    |=> timer_one_count[7:0] == $past(dat_i[7:0]))
    else $error("Timer write lost to trigger");
  a_adc_start: assert property (
    trig[1] && adc_enable_i |=> adc_start_o
    ##1 (!adc_start_o || $past(trig[1] && adc_enable_i)))
    else $error("Conversion start missing");

endmodule // dccu_top

// [rtl/dccu_map.svh]
`ifndef DCCU_MAP_SVH
`define DCCU_MAP_SVH
// Register indices; byte address is four times the index
`define DCCU_IDX_TMR_LO  8'h0e
`define DCCU_IDX_TMR_HI  8'h0f
`define DCCU_IDX_U0_LO   8'h15
`define DCCU_IDX_U0_HI   8'h16
`define DCCU_IDX_U0_CTRL 8'h17
`define DCCU_IDX_U1_LO   8'h1b
`define DCCU_IDX_U1_HI   8'h1c
`define DCCU_IDX_U1_CTRL 8'h1d
`define DCCU_IDX_FLAGS   8'h20
// Control field layout
`define DCCU_CTRL_W      6
`define DCCU_MODE_HI     3
`define DCCU_DUTY_HI     5
`define DCCU_DUTY_LO     4
`define DCCU_CTRL_RST    6'h00
// Mode codes
`define DCCU_MODE_OFF    4'h0
`define DCCU_MODE_FALL   4'h4
`define DCCU_MODE_RISE   4'h5
`define DCCU_MODE_RISE4  4'h6
`define DCCU_MODE_RISE16 4'h7
`define DCCU_MODE_SET    4'h8
`define DCCU_MODE_CLR    4'h9
`define DCCU_MODE_SOFT   4'ha
`define DCCU_MODE_TRIG   4'hb
// Prescaler terminal counts
`define DCCU_PS4_LAST    4'h3
`define DCCU_PS16_LAST   4'hf
// Flag register bits
`define DCCU_FLAG_OVF    2
`endif

// [rtl/dccu_pkg.sv]
package dccu_pkg;
  typedef enum logic [1:0] {
    DCCU_OFF,
    DCCU_CAPTURE,
    DCCU_COMPARE,
    DCCU_PWM
  } dccu_kind_e;
endpackage

// [tb/dccu_event_model.sv]
`timescale 1ns/100ps
// Event pads and timer one source; levels move only on clock edges
module dccu_event_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] level_i,
  input  wire logic       tick_req_i,
  output logic      [1:0] pin_o,
  output logic            tick_o
);
  initial begin
    pin_o = 2'b00;
    tick_o = 1'b0;
  end
  // Pad level is what the unit watches, whoever sets it
  always @(posedge clk_i) begin
    pin_o <= level_i;
  end
  // Same clock as the block: counting is never asynchronous
  always @(posedge clk_i) begin
    tick_o <= tick_req_i;
  end
endmodule // dccu_event_model

// [tb/dual_capture_compare_unit_test.sv]
`timescale 1ns/100ps
`include "dccu_map.svh"
module dual_capture_compare_unit_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        tick_req = 1'b0;
  logic        t2_hit = 1'b0;
  logic        adc_en = 1'b0;
  logic        ack, adc_go, tick;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0, rdat;
  logic [1:0]  pin_req = 2'b00;
  logic [1:0]  pad, pin;
  logic [1:0]  fine = 2'b00;
  logic [7:0]  t2 = 8'h01;
  logic [7:0]  q;
  logic [15:0] t, cap, v;
  int          err_total = 0;
  int          checks_done = 0;
  int          adc_cnt = 0;
  int          dv[4] = '{1, 1, 4, 16};
  int          np[4] = '{1, 2, 4, 16};
  int          cm[5] = '{8, 10, 9, 8, 0};
  logic        pe[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (adc_go === 1'b1) adc_cnt++;

  dccu_top #(.TIMER_W(16)) dccu_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(dat), .sel_i(4'hf), .dat_o(rdat), .ack_o(ack),
    .unit_pin_i(pad), .unit_pin_o(pin), .timer_one_tick_i(tick),
    .timer_two_count_i(t2), .timer_two_fine_i(fine),
    .timer_two_match_i(t2_hit), .adc_enable_i(adc_en), .adc_start_o(adc_go)
  );
  dccu_event_model dccu_event_model_i (
    .clk_i(clk_i), .level_i(pin_req), .tick_req_i(tick_req),
    .pin_o(pad), .tick_o(tick)
  );

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until ack is sampled; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    wb(1'b1, i, d);
  endtask
  task automatic rdv(input logic [7:0] i, output logic [15:0] r);
    wb(1'b0, i, 8'h00);
    r[7:0] = q;
    wb(1'b0, i + 8'h01, 8'h00);
    r[15:8] = q;
  endtask
  task automatic set16(input logic [7:0] i, input logic [15:0] d);
    wr(i, d[7:0]);
    wr(i + 8'h01, d[15:8]);
  endtask
  function automatic logic [7:0] lo(input int u);
    return (u == 0) ? `DCCU_IDX_U0_LO : `DCCU_IDX_U1_LO;
  endfunction
  task automatic chk_reg(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [1:0] e,
                         input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic t2p();
    t2_hit <= 1'b1;
    tk(1);
    t2_hit <= 1'b0;
    tk(3);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(32'he7fd));
    tk(3);
    rst_i <= 1'b0;
    rdv(`DCCU_IDX_U0_CTRL, v);
    chk_reg("control reset", 16'h0000, v);
    wr(`DCCU_IDX_U1_CTRL, 8'hff);
    rdv(`DCCU_IDX_U1_CTRL, v);
    chk_reg("control width", 16'h003f, {8'h00, v[7:0]});
    wr(`DCCU_IDX_U1_CTRL, 8'h00);
    rdv(8'h30, v);
    chk_reg("unmapped", 16'h0000, v);
    v = 16'($urandom);
    set16(`DCCU_IDX_U0_LO, v);
    rdv(`DCCU_IDX_U0_LO, cap);
    chk_reg("value pair", v, cap);
    for (int u = 0; u < 2; u++) for (int m = 0; m < 4; m++) begin
      wr(lo(u) + 8'h02, 8'h00);
      wr(lo(u) + 8'h02, 8'(4 + m));
      wr(`DCCU_IDX_FLAGS, 8'h07);
      for (int i = 0; i < np[m]; i++) begin
        t = 16'($urandom);
        set16(`DCCU_IDX_TMR_LO, t);
        pin_req[u] <= 1'b1;
        tk(6);
        if (m != 0) cap = t;
        t = 16'($urandom);
        set16(`DCCU_IDX_TMR_LO, t);
        pin_req[u] <= 1'b0;
        tk(6);
        if (m == 0) cap = t;
        rdv(`DCCU_IDX_FLAGS, v);
        chk_pin("capture flag", 2'(i + 1 >= dv[m]), 2'(v[u]));
      end
      rdv(lo(u), v);
      chk_reg("captured count", cap, v);
    end
    wr(`DCCU_IDX_U0_CTRL, 8'h00);
    v = 16'($urandom) | 16'h0100;
    set16(`DCCU_IDX_U0_LO, v);
    set16(`DCCU_IDX_TMR_LO, v);
    for (int k = 0; k < 5; k++) begin
      wr(`DCCU_IDX_U0_CTRL, 8'(cm[k]));
      tk(2);
      chk_pin("compare pin", 2'(pe[k]), 2'(pin[0]));
      wr(`DCCU_IDX_FLAGS, 8'h07);
      tk(2);
      rdv(`DCCU_IDX_FLAGS, t);
      chk_pin("compare flag", 2'(cm[k] != 0), 2'(t[0]));
    end
    adc_en <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      set16(lo(u), v);
      set16(`DCCU_IDX_TMR_LO, v);
      wr(`DCCU_IDX_FLAGS, 8'h07);
      adc_cnt = 0;
      wr(lo(u) + 8'h02, 8'h0b);
      tk(4);
      wr(lo(u) + 8'h02, 8'h00);
      rdv(`DCCU_IDX_TMR_LO, t);
      chk_reg("timer cleared", 16'h0000, t);
      rdv(`DCCU_IDX_FLAGS, t);
      chk_pin("trigger flags", 2'(1 << u),
              t[2] ? 2'b11 : t[1:0]);
      chk_pin("conversion start", 2'(u), 2'(adc_cnt != 0));
    end
    set16(`DCCU_IDX_TMR_LO, 16'hfffe);
    wr(`DCCU_IDX_FLAGS, 8'h07);
    tick_req <= 1'b1;
    tk(4);
    tick_req <= 1'b0;
    tk(2);
    rdv(`DCCU_IDX_TMR_LO, t);
    chk_reg("timer ticks", 16'h0002, t);
    rdv(`DCCU_IDX_FLAGS, t);
    chk_reg("overflow flag", 16'h0004, t);
    wr(`DCCU_IDX_U0_LO, 8'h80);
    wr(`DCCU_IDX_U1_LO, 8'h80);
    wr(`DCCU_IDX_U0_CTRL, 8'h0c);
    wr(`DCCU_IDX_U1_CTRL, 8'h1c);
    t2p();
    chk_pin("pwm rise", 2'b11, pin);
    t2 <= 8'h80;
    tk(3);
    chk_pin("pwm duty", 2'b10, pin);
    fine <= 2'b01;
    tk(3);
    chk_pin("pwm low bits", 2'b00, pin);
    wr(`DCCU_IDX_U0_LO, 8'h00);
    t2 <= 8'h01;
    t2p();
    chk_pin("pwm zero duty", 2'b10, pin);
    final_report();
  end
endmodule // dual_capture_compare_unit_test
